// ==== clock_power_module_pkg.sv ====
/*
 * Shared constants for the clock and power module: register map,
 * field positions, reset values, timing counts and state encodings.
 * Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus.
 */
package clock_power_module_pkg;

	// register bus
	localparam int unsigned ADDR_W         = 8;
	localparam int unsigned DATA_W         = 32;
	localparam logic [7:0]  OFS_SOFT_RESET = 8'h00;
	localparam logic [7:0]  OFS_PRIV_STATE = 8'h04;
	localparam logic [7:0]  OFS_POWER_CTRL = 8'h08;
	localparam logic [7:0]  OFS_STATUS     = 8'h0C;

	// power control fields
	localparam int unsigned CTRL_W         = 4;
	localparam int unsigned CTRL_KEEP_CLK  = 0;
	localparam int unsigned CTRL_KEEP_PWR  = 1;
	localparam int unsigned CTRL_OVERRIDE  = 2;
	localparam int unsigned CTRL_IDLE_LP   = 3;
	localparam logic [3:0]  CTRL_RESET     = 4'h0;

	// privilege state and access protection bits
	localparam int unsigned PROT_PRIV      = 0;
	localparam int unsigned PROT_NS        = 1;
	localparam logic        PRIV_RESET     = 1'b1;
	localparam logic        NS_RESET       = 1'b0;

	// status fields
	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_CLK_Q     = 3;
	localparam int unsigned STAT_PWR_Q     = 4;

	// timing
	localparam int unsigned CLK_PERIOD_PS    = 10000;
	localparam int unsigned SYS_RST_HOLD_NS  = 40;
	localparam int unsigned SYS_RST_HOLD_CYC = (SYS_RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned GATE_TO_RST_MAX  = 2;
	localparam int unsigned TIMER_W          = 4;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_DMA_WAIT = 3'b001,
		ST_GATE     = 3'b011,
		ST_SYS_RST  = 3'b010,
		ST_RAM_CLR  = 3'b110,
		ST_UPDATE   = 3'b111
	} seq_state_t;

	typedef enum logic [1:0] {
		Q_RUN  = 2'b00,
		Q_STOP = 2'b01,
		Q_DENY = 2'b10
	} q_state_t;

endpackage : clock_power_module_pkg

// ==== step_timer.sv ====
/*
 * Down counter that times one step of the reset sequence.
 * Assumes load_i is a single-cycle pulse from the sequencer.
 */
`timescale 1ns/1ps
`default_nettype none
module step_timer #(
	parameter int unsigned W   = 4,
	parameter logic [W-1:0] LEN = W'(4)
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// control
	input  wire logic load_i,
	output logic      done_o
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;

	always_comb begin
		count_nxt = count_r;
		if (load_i) begin
			count_nxt = LEN - W'(1);
		end else if (count_r != '0) begin
			count_nxt = count_r - W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign done_o = (count_r == '0);
endmodule : step_timer
`default_nettype wire

// ==== q_channel_port.sv ====
/*
 * Device end of one Q-Channel low-power handshake.
 * Assumes the controller drives qreqn_i synchronously and holds it
 * low until it sees accept or deny.
 */
`timescale 1ns/1ps
`default_nettype none
module q_channel_port
	import clock_power_module_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// local policy
	input  wire logic allow_i,
	// q-channel
	input  wire logic qreqn_i,
	output logic      qacceptn_o,
	output logic      qdeny_o,
	output logic      qactive_o
);
	q_state_t st_r;
	q_state_t st_nxt;
	logic     acc_r;
	logic     deny_r;
	logic     act_r;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			Q_RUN: begin
				if (!qreqn_i) begin
					st_nxt = allow_i ? Q_STOP : Q_DENY;
				end
			end
			Q_STOP: begin
				if (qreqn_i) begin
					st_nxt = Q_RUN;
				end
			end
			Q_DENY: begin
				if (qreqn_i) begin
					st_nxt = Q_RUN;
				end
			end
			default: st_nxt = Q_RUN;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r   <= Q_RUN;
			acc_r  <= 1'b1;
			deny_r <= 1'b0;
			act_r  <= 1'b1;
		end else begin
			st_r   <= st_nxt;
			acc_r  <= (st_nxt != Q_STOP);
			deny_r <= (st_nxt == Q_DENY);
			act_r  <= !allow_i;
		end
	end

	assign qacceptn_o = acc_r;
	assign qdeny_o    = deny_r;
	assign qactive_o  = act_r;

	property p_accept_only_allowed;
		@(posedge clk_i) disable iff (rst_i)
		$fell(qacceptn_o) |-> $past(allow_i) && !$past(qreqn_i);
	endproperty
	a_accept_only_allowed: assert property (p_accept_only_allowed) else $error("stop accepted while not allowed");
endmodule : q_channel_port
`default_nettype wire

// ==== clock_power_module.sv ====
/*
 * Clock and power module: reset sequencer, soft-reset access check,
 * privilege state, main clock gate enables and two Q-Channel ends,
 * with a classic Wishbone register slave.
 * Assumes one clock, rst_i is the hard reset from an outside reset
 * controller, and the gated clocks are built from the enables here.
 */
// Design decisions made here: the register offsets and register access over Wishbone.
// Contract
// - hard reset input starts a hard reset sequence
// - permitted write to soft-reset register starts a soft reset
// - access allowed only if prot[0] >= privilege and prot[1] <= nonsecure
// - any reset clears all registers and internal memories
// - soft reset: DMA clock on, request DMA, wait for acknowledge
// - with core clock off, assert system reset within two cycles
// - after release, memory and DMA clocks on, signal RAM clear
// - last step updates stored privilege and security level
// - core clock runs except while reset is in progress
// - stopped device tells clock Q-Channel its clock may stop
// - a control bit keeps the clock requested while stopped
// - stopped device offers power-off; a control bit keeps power
// - one main clock gate upstream of block gates
// - module can override block-level clock gates
// - optionally request low power while idle
// - exactly one clock and one reset
`timescale 1ns/1ps
`default_nettype none
module clock_power_module
	import clock_power_module_pkg::*;
(
	// clock and hard reset
	input  wire logic                                    clk_i,
	input  wire logic                                    rst_i,
	// wishbone slave
	input  wire logic                                    wb_cyc_i,
	input  wire logic                                    wb_stb_i,
	input  wire logic                                    wb_we_i,
	input  wire logic [clock_power_module_pkg::ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                              wb_sel_i,
	input  wire logic [clock_power_module_pkg::DATA_W-1:0] wb_dat_i,
	input  wire logic [1:0]                              wb_prot_i,
	output logic                                         wb_ack_o,
	output logic [clock_power_module_pkg::DATA_W-1:0]      wb_dat_o,
	// boot privilege straps and device status
	input  wire logic                                    boot_priv_i,
	input  wire logic                                    boot_nonsecure_i,
	input  wire logic                                    npu_stopped_i,
	input  wire logic                                    queue_idle_i,
	// dma and memory handshakes
	input  wire logic                                    dma_reset_ack_i,
	input  wire logic                                    ram_clear_done_i,
	output logic                                         dma_soft_reset_req_o,
	output logic                                         ram_clear_o,
	output logic                                         sys_reset_o,
	// clock enables
	output logic                                         main_clk_en_o,
	output logic                                         dma_clk_en_o,
	output logic                                         mem_clk_en_o,
	output logic                                         block_gate_override_o,
	// privilege state
	output logic                                         current_privilege_level_o,
	output logic                                         current_nonsecure_flag_o,
	// clock q-channel
	input  wire logic                                    clk_qreqn_i,
	output logic                                         clk_qacceptn_o,
	output logic                                         clk_qdeny_o,
	output logic                                         clk_qactive_o,
	// power q-channel
	input  wire logic                                    pwr_qreqn_i,
	output logic                                         pwr_qacceptn_o,
	output logic                                         pwr_qdeny_o,
	output logic                                         pwr_qactive_o
);
	import clock_power_module_pkg::*;

	// sequencer state
	seq_state_t  state_r;
	seq_state_t  state_nxt;
	logic        src_soft_r;
	logic        src_soft_nxt;
	logic        pend_priv_r;
	logic        pend_priv_nxt;
	logic        pend_ns_r;
	logic        pend_ns_nxt;
	logic        cur_priv_r;
	logic        cur_priv_nxt;
	logic        cur_ns_r;
	logic        cur_ns_nxt;
	logic        hold_done;
	// register file
	logic [CTRL_W-1:0] ctrl_r;
	logic [CTRL_W-1:0] ctrl_nxt;
	logic              ack_r;
	logic              ack_nxt;
	logic [DATA_W-1:0] rdat_r;
	logic [DATA_W-1:0] rdat_nxt;
	// decode
	logic        wb_hit;
	logic        permit;
	logic        soft_go;
	logic        seq_idle;
	logic        allow_clk;
	logic        allow_pwr;

	assign wb_hit   = wb_cyc_i && wb_stb_i && !ack_r;
	// privilege check on the protection bits of this access
	assign permit   = (wb_prot_i[PROT_PRIV] >= cur_priv_r) && (wb_prot_i[PROT_NS] <= cur_ns_r);
	assign soft_go  = wb_hit && wb_we_i && (wb_adr_i == OFS_SOFT_RESET) && wb_sel_i[0] && permit
	                  && (state_r == ST_IDLE);
	assign seq_idle = (state_r == ST_IDLE);
	// low-power offers only when no reset runs and software does not pin them
	assign allow_clk = seq_idle && !ctrl_r[CTRL_KEEP_CLK]
	                   && (npu_stopped_i || (ctrl_r[CTRL_IDLE_LP] && queue_idle_i));
	assign allow_pwr = seq_idle && !ctrl_r[CTRL_KEEP_PWR]
	                   && (npu_stopped_i || (ctrl_r[CTRL_IDLE_LP] && queue_idle_i));

	step_timer #(
		.W   (TIMER_W),
		.LEN (TIMER_W'(SYS_RST_HOLD_CYC))
	) u_hold (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.load_i (state_r == ST_GATE),
		.done_o (hold_done)
	);

	// reset sequencer
	always_comb begin
		state_nxt     = state_r;
		src_soft_nxt  = src_soft_r;
		pend_priv_nxt = pend_priv_r;
		pend_ns_nxt   = pend_ns_r;
		cur_priv_nxt  = cur_priv_r;
		cur_ns_nxt    = cur_ns_r;
		case (state_r)
			ST_IDLE: begin
				if (soft_go) begin
					state_nxt     = ST_DMA_WAIT;
					src_soft_nxt  = 1'b1;
					pend_priv_nxt = wb_prot_i[PROT_PRIV];
					pend_ns_nxt   = wb_prot_i[PROT_NS];
				end
			end
			ST_DMA_WAIT: begin
				if (dma_reset_ack_i) begin
					state_nxt = ST_GATE;
				end
			end
			ST_GATE: begin
				state_nxt = ST_SYS_RST;
			end
			ST_SYS_RST: begin
				if (hold_done) begin
					state_nxt = ST_RAM_CLR;
				end
			end
			ST_RAM_CLR: begin
				if (ram_clear_done_i) begin
					state_nxt = ST_UPDATE;
				end
			end
			ST_UPDATE: begin
				// soft reset adopts the requester's level, hard reset the straps
				cur_priv_nxt = src_soft_r ? pend_priv_r : boot_priv_i;
				cur_ns_nxt   = src_soft_r ? pend_ns_r : boot_nonsecure_i;
				src_soft_nxt = 1'b0;
				state_nxt    = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// hard reset lands straight in the gate step
			state_r               <= ST_GATE;
			src_soft_r            <= 1'b0;
			pend_priv_r           <= PRIV_RESET;
			pend_ns_r             <= NS_RESET;
			cur_priv_r            <= PRIV_RESET;
			cur_ns_r              <= NS_RESET;
			main_clk_en_o         <= 1'b0;
			dma_clk_en_o          <= 1'b0;
			mem_clk_en_o          <= 1'b0;
			dma_soft_reset_req_o  <= 1'b0;
			sys_reset_o           <= 1'b0;
			ram_clear_o           <= 1'b0;
		end else begin
			state_r               <= state_nxt;
			src_soft_r            <= src_soft_nxt;
			pend_priv_r           <= pend_priv_nxt;
			pend_ns_r             <= pend_ns_nxt;
			cur_priv_r            <= cur_priv_nxt;
			cur_ns_r              <= cur_ns_nxt;
			// one main gate feeds every block gate below it
			main_clk_en_o         <= (state_nxt == ST_IDLE);
			dma_clk_en_o          <= (state_nxt == ST_IDLE) || (state_nxt == ST_DMA_WAIT)
			                         || (state_nxt == ST_RAM_CLR);
			mem_clk_en_o          <= (state_nxt == ST_IDLE) || (state_nxt == ST_RAM_CLR);
			dma_soft_reset_req_o  <= (state_nxt == ST_DMA_WAIT);
			sys_reset_o           <= (state_nxt == ST_SYS_RST);
			ram_clear_o           <= (state_nxt == ST_RAM_CLR);
		end
	end

	// register slave
	always_comb begin
		ctrl_nxt = ctrl_r;
		ack_nxt  = wb_hit;
		rdat_nxt = '0;
		if (wb_hit && wb_we_i && (wb_adr_i == OFS_POWER_CTRL) && wb_sel_i[0]) begin
			ctrl_nxt = wb_dat_i[CTRL_W-1:0];
		end
		if (wb_hit && !wb_we_i) begin
			case (wb_adr_i)
				OFS_PRIV_STATE: begin
					rdat_nxt[PROT_PRIV] = cur_priv_r;
					rdat_nxt[PROT_NS]   = cur_ns_r;
				end
				OFS_POWER_CTRL: begin
					rdat_nxt[CTRL_W-1:0] = ctrl_r;
				end
				OFS_STATUS: begin
					rdat_nxt[STAT_STATE_LSB +: 3] = state_r;
					rdat_nxt[STAT_CLK_Q]          = !clk_qacceptn_o;
					rdat_nxt[STAT_PWR_Q]          = !pwr_qacceptn_o;
				end
				default: rdat_nxt = '0;
			endcase
		end
		// settings do not survive a reset of either kind
		if (state_r == ST_SYS_RST) begin
			ctrl_nxt = CTRL_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r                <= CTRL_RESET;
			ack_r                 <= 1'b0;
			rdat_r                <= '0;
			block_gate_override_o <= 1'b0;
		end else begin
			ctrl_r                <= ctrl_nxt;
			ack_r                 <= ack_nxt;
			rdat_r                <= rdat_nxt;
			block_gate_override_o <= ctrl_nxt[CTRL_OVERRIDE];
		end
	end

	assign wb_ack_o                  = ack_r;
	assign wb_dat_o                  = rdat_r;
	assign current_privilege_level_o = cur_priv_r;
	assign current_nonsecure_flag_o  = cur_ns_r;

	q_channel_port u_clk_q (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.allow_i    (allow_clk),
		.qreqn_i    (clk_qreqn_i),
		.qacceptn_o (clk_qacceptn_o),
		.qdeny_o    (clk_qdeny_o),
		.qactive_o  (clk_qactive_o)
	);

	q_channel_port u_pwr_q (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.allow_i    (allow_pwr),
		.qreqn_i    (pwr_qreqn_i),
		.qacceptn_o (pwr_qacceptn_o),
		.qdeny_o    (pwr_qdeny_o),
		.qactive_o  (pwr_qactive_o)
	);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_hard_reset_seq;
		$fell(rst_i) |-> ##[1:2] sys_reset_o;
	endproperty
	a_hard_reset_seq: assert property (p_hard_reset_seq) else $error("hard reset did not start sequence");

	property p_soft_start;
		soft_go |=> dma_soft_reset_req_o && dma_clk_en_o && !sys_reset_o;
	endproperty
	a_soft_start: assert property (p_soft_start) else $error("permitted write did not start soft reset");

	property p_refused;
		(wb_hit && wb_we_i && wb_adr_i == OFS_SOFT_RESET && !permit && seq_idle) |=> !dma_soft_reset_req_o;
	endproperty
	a_refused: assert property (p_refused) else $error("refused write started a reset");

	property p_dma_wait;
		(dma_soft_reset_req_o && !dma_reset_ack_i) |=> !sys_reset_o && !main_clk_en_o;
	endproperty
	a_dma_wait: assert property (p_dma_wait) else $error("reset advanced before dma acknowledge");

	property p_gate_to_reset;
		$fell(dma_soft_reset_req_o) |-> !main_clk_en_o ##[0:2] sys_reset_o;
	endproperty
	a_gate_to_reset: assert property (p_gate_to_reset) else $error("system reset late after gate");

	property p_ram_clear;
		$fell(sys_reset_o) |-> ram_clear_o && mem_clk_en_o && dma_clk_en_o;
	endproperty
	a_ram_clear: assert property (p_ram_clear) else $error("ram clear not signalled after reset");

	property p_update_priv;
		(state_r == ST_UPDATE && src_soft_r) |=> current_privilege_level_o == $past(pend_priv_r)
		                                        && current_nonsecure_flag_o == $past(pend_ns_r);
	endproperty
	a_update_priv: assert property (p_update_priv) else $error("privilege state not updated");

	property p_clears_ctrl;
		$rose(sys_reset_o) |=> ##1 ctrl_r == CTRL_RESET;
	endproperty
	a_clears_ctrl: assert property (p_clears_ctrl) else $error("settings survived reset");

	property p_clock_runs;
		(state_r == ST_IDLE) && $past(state_r == ST_IDLE) |-> main_clk_en_o;
	endproperty
	a_clock_runs: assert property (p_clock_runs) else $error("core clock stopped outside reset");

	property p_order;
		sys_reset_o |-> !ram_clear_o && !dma_soft_reset_req_o;
	endproperty
	a_order: assert property (p_order) else $error("reset steps overlap");

	property p_keep_clk;
		ctrl_r[CTRL_KEEP_CLK] |=> clk_qactive_o;
	endproperty
	a_keep_clk: assert property (p_keep_clk) else $error("clock offered while kept");

	property p_override;
		ctrl_r[CTRL_OVERRIDE] && state_r != ST_SYS_RST |-> block_gate_override_o;
	endproperty
	a_override: assert property (p_override) else $error("block gate override not driven");
endmodule : clock_power_module
`default_nettype wire

// ==== q_ctrl_model.sv ====
/*
 * Q-Channel controller model: asks the device to quiesce, then lets it run again.
 * Assumes the device answers within a few cycles of clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module q_ctrl_model (
	// clock
	input  wire logic clk_i,
	// q-channel
	output logic      qreqn_o,
	input  wire logic qacceptn_i,
	input  wire logic qdeny_i
);
	initial qreqn_o = 1'b1;
	// granted: 1 accept, 0 deny, x no answer
	task automatic quiesce(output logic granted);
		int n;
		granted = 1'bx;
		@(posedge clk_i);
		qreqn_o <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (qacceptn_i === 1'b1 && qdeny_i === 1'b0 && n < 20);
		if (qacceptn_i === 1'b0) granted = 1'b1;
		else if (qdeny_i === 1'b1) granted = 1'b0;
		// request is held until answered, or withdrawn after 20 cycles without an answer
		qreqn_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((qacceptn_i !== 1'b1 || qdeny_i !== 1'b0) && n < 20);
	endtask : quiesce
endmodule : q_ctrl_model
`default_nettype wire

// ==== npu_clock_power_reset_module_tb.sv ====
/*
 * Self-checking bench for the clock and power module.
 * Assumes the design package and q_ctrl_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module npu_clock_power_reset_module_tb;
	import clock_power_module_pkg::*;
	logic              clk_i = 1'b0, rst_i = 1'b1;
	logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0]        wb_adr_i = 8'h00;
	logic [31:0]       wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
	logic [1:0]        wb_prot_i = 2'h0;
	logic              boot_priv_i = 1'b1, boot_nonsecure_i = 1'b0, npu_stopped_i = 1'b0, queue_idle_i = 1'b0;
	logic              dma_reset_ack_i = 1'b0, ram_clear_done_i = 1'b0;
	logic              dma_soft_reset_req_o, ram_clear_o, sys_reset_o, main_clk_en_o, dma_clk_en_o, mem_clk_en_o;
	logic              block_gate_override_o, current_privilege_level_o, current_nonsecure_flag_o;
	logic              clk_qreqn, clk_qacceptn_o, clk_qdeny_o, pwr_qreqn, pwr_qacceptn_o, pwr_qdeny_o;
	logic              clk_qactive_o, pwr_qactive_o;
	logic              got, exp;
	logic [31:0]       exp_q[$];
	logic [5:0]        q_case[6] = '{6'h02, 6'h06, 6'h0A, 6'h21, 6'h20, 6'h12};
	int                n_errors = 0, check_count = 0, hs_cnt = 0, hs_lim = 2, seed_v;

	always #5 clk_i = ~clk_i;

	clock_power_module dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_prot_i(wb_prot_i),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .boot_priv_i(boot_priv_i), .boot_nonsecure_i(boot_nonsecure_i),
		.npu_stopped_i(npu_stopped_i), .queue_idle_i(queue_idle_i), .dma_reset_ack_i(dma_reset_ack_i),
		.ram_clear_done_i(ram_clear_done_i), .dma_soft_reset_req_o(dma_soft_reset_req_o),
		.ram_clear_o(ram_clear_o), .sys_reset_o(sys_reset_o), .main_clk_en_o(main_clk_en_o),
		.dma_clk_en_o(dma_clk_en_o), .mem_clk_en_o(mem_clk_en_o), .block_gate_override_o(block_gate_override_o),
		.current_privilege_level_o(current_privilege_level_o), .current_nonsecure_flag_o(current_nonsecure_flag_o),
		.clk_qreqn_i(clk_qreqn), .clk_qacceptn_o(clk_qacceptn_o), .clk_qdeny_o(clk_qdeny_o),
		.clk_qactive_o(clk_qactive_o), .pwr_qreqn_i(pwr_qreqn), .pwr_qacceptn_o(pwr_qacceptn_o),
		.pwr_qdeny_o(pwr_qdeny_o), .pwr_qactive_o(pwr_qactive_o));
	q_ctrl_model clk_q_u (.clk_i(clk_i), .qreqn_o(clk_qreqn), .qacceptn_i(clk_qacceptn_o), .qdeny_i(clk_qdeny_o));
	q_ctrl_model pwr_q_u (.clk_i(clk_i), .qreqn_o(pwr_qreqn), .qacceptn_i(pwr_qacceptn_o), .qdeny_i(pwr_qdeny_o));

	// dma and memory answer after a random stall
	always @(posedge clk_i) begin
		hs_cnt <= (dma_soft_reset_req_o | ram_clear_o) ? hs_cnt + 1 : 0;
		dma_reset_ack_i <= dma_soft_reset_req_o && hs_cnt >= hs_lim;
		ram_clear_done_i <= ram_clear_o && hs_cnt >= hs_lim;
	end

	task automatic chk_bit(input string what, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", what, e, g);
		end
	endtask : chk_bit

	task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : chk_word

	// read results are taken off the queue as the answer arrives
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0) begin
			chk_word("read data", exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_BEEF, wb_dat_o);
		end
	end

	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask : tick

	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [1:0] prot);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_prot_i <= prot;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		chk_bit("bus answer", 1'b1, wb_ack_o);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_xfer

	task automatic wb_read(input logic [7:0] adr, input logic [31:0] e);
		exp_q.push_back(e);
		wb_xfer(1'b0, adr, 32'h0000_0000, 2'h1);
	endtask : wb_read

	// gate, system reset, ram clear, update, back to idle
	task automatic seq_tail(input logic ep, input logic ens);
		int n;
		n = 0;
		while (dma_soft_reset_req_o === 1'b1 && n < 50) begin
			tick();
			n++;
		end
		n = 0;
		while (sys_reset_o !== 1'b1 && n < 8) begin
			chk_bit("main clock off before system reset", 1'b0, main_clk_en_o);
			tick();
			n++;
		end
		chk_bit("system reset within two cycles", 1'b1, n <= 2);
		n = 0;
		while (sys_reset_o === 1'b1 && n < 20) begin
			chk_bit("clocks off in system reset", 1'b0, main_clk_en_o | mem_clk_en_o);
			tick();
			n++;
		end
		chk_word("system reset length", 32'(SYS_RST_HOLD_CYC), 32'(n));
		chk_bit("ram clear", 1'b1, ram_clear_o & mem_clk_en_o & dma_clk_en_o);
		n = 0;
		while (main_clk_en_o !== 1'b1 && n < 50) begin
			tick();
			n++;
		end
		chk_bit("ram clear done", 1'b0, ram_clear_o);
		chk_bit("privilege level", ep, current_privilege_level_o);
		chk_bit("nonsecure flag", ens, current_nonsecure_flag_o);
	endtask : seq_tail

	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run

	initial begin
		#200_000;
		chk_bit("run finished in time", 1'b1, 1'b0);
		complete_run();
	end

	initial begin
		seed_v = $urandom(32'h55e8058e);
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		seq_tail(1'b1, 1'b0);
		wb_read(OFS_POWER_CTRL, 32'h0000_0000);
		wb_read(OFS_STATUS, 32'h0000_0000);
		rd = $urandom;
		wb_xfer(1'b1, OFS_POWER_CTRL, rd, 2'h1);
		wb_read(OFS_POWER_CTRL, {28'h000_0000, rd[3:0]});
		chk_bit("block gate override", rd[CTRL_OVERRIDE], block_gate_override_o);
		wb_xfer(1'b1, OFS_PRIV_STATE, 32'hFFFF_FFFF, 2'h1);
		wb_read(OFS_PRIV_STATE, 32'h0000_0001);
		wb_xfer(1'b1, 8'h40, 32'hFFFF_FFFF, 2'h1);
		wb_read(8'h40, 32'h0000_0000);
		for (int i = 0; i < 6; i++) begin
			wb_xfer(1'b1, OFS_POWER_CTRL, {28'h000_0000, q_case[i][5:2]}, 2'h1);
			@(posedge clk_i);
			npu_stopped_i <= q_case[i][1];
			queue_idle_i <= q_case[i][0];
			repeat (3) @(posedge clk_i);
			exp = q_case[i][1] || (q_case[i][5] && q_case[i][0]);
			chk_bit("clock q active", !(exp && !q_case[i][2]), clk_qactive_o);
			chk_bit("power q active", !(exp && !q_case[i][3]), pwr_qactive_o);
			clk_q_u.quiesce(got);
			chk_bit("clock q-channel grant", exp && !q_case[i][2], got);
			pwr_q_u.quiesce(got);
			chk_bit("power q-channel grant", exp && !q_case[i][3], got);
		end
		npu_stopped_i <= 1'b0;
		for (int p = 0; p < 4; p++) begin
			hs_lim = $urandom_range(2, 6);
			wb_xfer(1'b1, OFS_POWER_CTRL, 32'h0000_000F, 2'h1);
			wb_xfer(1'b1, OFS_SOFT_RESET, $urandom, p[1:0]);
			#1;
			exp = (p == 1);
			chk_bit("soft reset taken", exp, dma_soft_reset_req_o);
			chk_bit("main clock gate", !exp, main_clk_en_o);
			if (exp) begin
				chk_bit("dma clock kept on", 1'b1, dma_clk_en_o);
				seq_tail(1'b1, 1'b0);
				wb_read(OFS_POWER_CTRL, 32'h0000_0000);
			end
		end
		wb_xfer(1'b1, OFS_POWER_CTRL, 32'h0000_000F, 2'h1);
		@(posedge clk_i);
		boot_priv_i <= 1'b0;
		boot_nonsecure_i <= 1'b1;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		seq_tail(1'b0, 1'b1);
		wb_read(OFS_POWER_CTRL, 32'h0000_0000);
		wb_xfer(1'b1, OFS_SOFT_RESET, 32'h0000_0001, 2'h2);
		#1;
		chk_bit("soft reset taken", 1'b1, dma_soft_reset_req_o);
		seq_tail(1'b0, 1'b1);
		complete_run();
	end
endmodule : npu_clock_power_reset_module_tb
`default_nettype wire
